//--- logic/mcf_pkg.sv
// Build-time constants, register offsets and types for the multichannel shared FIFO
package mcf_pkg;
  // Channels
  localparam int NUM_CH = 4;
  localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  localparam logic [CH_W-1:0] CH_LAST = CH_W'(NUM_CH - 1);
  // Data beat layout
  localparam int SYM_PER_BEAT = 4;
  localparam int BITS_PER_SYM = 8;
  localparam int DATA_W = SYM_PER_BEAT * BITS_PER_SYM;
  localparam int ERR_W = 1;
  // Per-channel segment
  localparam int ADDR_W = 4;
  localparam int DEPTH = 2 ** ADDR_W;
  localparam int PTR_W = ADDR_W + 1;
  localparam int MEM_WORDS = NUM_CH * DEPTH;
  localparam int WORD_W = DATA_W + ERR_W + 2;
  localparam logic [PTR_W-1:0] SEG_FULL = PTR_W'(DEPTH);
  // Build options
  localparam bit USE_PACKETS = 1'b1;
  localparam bit USE_FILL = 1'b1;
  localparam bit USE_REQUEST = 1'b1;
  localparam bit PKT_BUF_MODE = 1'b1;
  localparam bit DROP_ON_ERR = 1'b1;
  localparam int NUM_AF = 2;
  localparam int NUM_AE = 2;
  localparam logic [PTR_W-1:0] SECT_AVAIL = 5'h04;
  // Register ports
  localparam int REG_W = 32;
  localparam int CTL_ADDR_W = 4;
  localparam int FILL_ADDR_W = CH_W + 2;
  localparam logic [CTL_ADDR_W-1:0] AF_THR_OFS = 4'h0;
  localparam logic [CTL_ADDR_W-1:0] AE_THR_OFS = 4'h4;
  localparam logic [CTL_ADDR_W-1:0] AF2_THR_OFS = 4'h8;
  localparam logic [CTL_ADDR_W-1:0] AE2_THR_OFS = 4'hc;
  localparam logic [REG_W-1:0] THR_RST = 32'h0000_0000;
  // Request pipeline
  typedef enum logic [1:0] {
    RQ_IDLE = 2'b00,
    RQ_MEM = 2'b01,
    RQ_LOAD = 2'b10,
    RQ_SHOW = 2'b11
  } mcf_rq_t;
endpackage

//--- logic/mcf_fifo.sv
// Multichannel FIFO in one shared memory, with request, control, fill and status ports
//
// Behaviour
// - Data sink and source use valid/ready, beat moves in the cycle ready is high.
// - Status outputs carry 2 bits, one symbol, a channel, no backpressure or framing.
// - Channel count is one of 1, 2, 4, 8, 16; channel fields cover it.
// - Almost-full and almost-empty thresholds are shared by all channels.
// - Fill-level read returns chosen channel's level, data one cycle after read.
// - Host writes channel number as request address; one word per request.
// - Without request option, strobe held high and channel select held zero.
// - Several channels without request option: only channel zero is served.
// - One memory split in equal per-channel segments; each channel keeps order.
// - Drop-on-error discards errored packet whole; else store and forward the error.
// - With packets on, requested data leaves only after a full packet; otherwise valid stays low.
// - Requested data appears three cycles after request; one word outstanding.
// - Threshold status walks round-robin, one channel per cycle.
// - Data width is symbols per beat times bits per symbol, each 1 to 32.
// - Error field width is a build constant from 0 to 32.
// - Segment depth is two to the address width, width 1 to 32.
// - Start and end of packet exist only with packet support on; here the ports are always present and read as zero without it.
// - Fill-level port exists only with fill option set; here the port is always present and reads zero without it.
// - Zero to two almost-full and almost-empty thresholds enabled.
// - Without packets, data leaves once the section amount has gathered.
// - Packet-buffer mode with packets on sends only whole packets.
// - Almost-full bit 0/1 set when level at or above primary/secondary threshold.
// - Almost-empty bit 0/1 set when level at or below primary/secondary threshold.
`timescale 1ns/1ps
module mcf_fifo
  import mcf_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Streaming sink
  input wire logic inValid,
  output logic inReady,
  input wire logic [DATA_W-1:0] inData,
  input wire logic [CH_W-1:0] inChannel,
  input wire logic inSop,
  input wire logic inEop,
  input wire logic [ERR_W-1:0] inError,
  // Streaming source
  output logic outValid,
  input wire logic outReady,
  output logic [DATA_W-1:0] outData,
  output logic [CH_W-1:0] outChannel,
  output logic outSop,
  output logic outEop,
  output logic [ERR_W-1:0] outError,
  // Request port
  input wire logic reqWrite,
  input wire logic [CH_W-1:0] reqAddr,
  output logic reqReady,
  // Control port
  input wire logic [CTL_ADDR_W-1:0] ctlAddr,
  input wire logic [REG_W-1:0] ctlWdata,
  input wire logic ctlWr,
  input wire logic ctlRd,
  output logic [REG_W-1:0] ctlRdata,
  // Fill-level port
  input wire logic [FILL_ADDR_W-1:0] fillAddr,
  input wire logic fillRd,
  output logic [REG_W-1:0] fillRdata,
  // Threshold status
  output logic afValid,
  output logic [1:0] afData,
  output logic [CH_W-1:0] afChannel,
  output logic aeValid,
  output logic [1:0] aeData,
  output logic [CH_W-1:0] aeChannel
);

  // Storage and per-channel pointers
  logic [WORD_W-1:0] mem [MEM_WORDS];
  logic [MEM_WORDS-1:0] eopFlag;
  logic [WORD_W-1:0] memQ;
  logic [PTR_W-1:0] wrPtr [NUM_CH];
  logic [PTR_W-1:0] commitPtr [NUM_CH];
  logic [PTR_W-1:0] rdPtr [NUM_CH];
  logic [PTR_W-1:0] pktCnt [NUM_CH];
  logic [PTR_W-1:0] level [NUM_CH];
  logic [NUM_CH-1:0] errSeen;
  logic [NUM_CH-1:0] hasSpace;
  logic [NUM_CH-1:0] eligible;

  // Request pipeline
  mcf_rq_t rqState;
  logic [CH_W+ADDR_W-1:0] rdAddrReg;

  // Thresholds
  logic [REG_W-1:0] afThr;
  logic [REG_W-1:0] aeThr;
  logic [REG_W-1:0] af2Thr;
  logic [REG_W-1:0] ae2Thr;

  // Write side decode
  wire logic inFire;
  wire logic inErrAny;
  wire logic pktSop;
  wire logic pktEop;
  wire logic dropNow;
  wire logic [CH_W+ADDR_W-1:0] wrAddr;
  wire logic [WORD_W-1:0] wordIn;
  wire logic [PTR_W-1:0] inLevel;

  assign inReady = hasSpace[inChannel];
  assign inFire = inValid && inReady;
  assign inErrAny = |inError;
  assign pktSop = USE_PACKETS && inSop;
  assign pktEop = USE_PACKETS && inEop;
  assign dropNow = PKT_BUF_MODE && DROP_ON_ERR && pktEop &&
                   (errSeen[inChannel] || inErrAny);
  assign wrAddr = {inChannel, wrPtr[inChannel][ADDR_W-1:0]};
  assign wordIn = {inError, pktEop, pktSop, inData};
  assign inLevel = level[inChannel];

  // Read side decode; no request port means a constant request for channel 0
  wire logic reqStrobe;
  wire logic [CH_W-1:0] reqChSel;
  wire logic reqTake;
  wire logic reqGo;
  wire logic [CH_W+ADDR_W-1:0] rdAddrNow;
  wire logic rdIsEop;

  assign reqStrobe = USE_REQUEST ? reqWrite : 1'b1;
  assign reqChSel = USE_REQUEST ? reqAddr : '0;
  assign reqReady = (rqState == RQ_IDLE);
  assign reqTake = reqStrobe && reqReady;
  assign reqGo = reqTake && eligible[reqChSel];
  assign rdAddrNow = {reqChSel, rdPtr[reqChSel][ADDR_W-1:0]};
  assign rdIsEop = eopFlag[rdAddrNow];

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic wrHit;
    logic rdHit;
    logic pktDone;
    logic pktGone;
    assign wrHit = inFire && (inChannel == CH_W'(g));
    assign rdHit = reqGo && (reqChSel == CH_W'(g));
    assign pktDone = wrHit && pktEop && !dropNow;
    assign pktGone = rdHit && USE_PACKETS && rdIsEop;
    // Level counts committed words only, so a packet being dropped never shows
    assign level[g] = commitPtr[g] - rdPtr[g];
    // Space counts every stored word, committed or not
    assign hasSpace[g] = (wrPtr[g] - rdPtr[g]) != SEG_FULL;
    assign eligible[g] = USE_PACKETS ? (pktCnt[g] != '0) :
                         ((level[g] >= SECT_AVAIL) && (level[g] != '0));

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        rdPtr[g] <= '0;
        pktCnt[g] <= '0;
      end else begin
        if (rdHit) begin
          rdPtr[g] <= rdPtr[g] + PTR_W'(1);
        end
        pktCnt[g] <= pktCnt[g] + PTR_W'(pktDone) - PTR_W'(pktGone);
      end
    end

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        wrPtr[g] <= '0;
        commitPtr[g] <= '0;
        errSeen[g] <= 1'b0;
      end else if (wrHit) begin
        if (!USE_PACKETS) begin
          wrPtr[g] <= wrPtr[g] + PTR_W'(1);
          commitPtr[g] <= wrPtr[g] + PTR_W'(1);
        end else if (pktEop) begin
          errSeen[g] <= 1'b0;
          if (dropNow) begin
            wrPtr[g] <= commitPtr[g];
          end else begin
            wrPtr[g] <= wrPtr[g] + PTR_W'(1);
            commitPtr[g] <= wrPtr[g] + PTR_W'(1);
          end
        end else begin
          wrPtr[g] <= wrPtr[g] + PTR_W'(1);
          errSeen[g] <= errSeen[g] || inErrAny;
        end
      end
    end
  end

  // Shared memory; no reset, only committed words are ever read
  always_ff @(posedge clk_sys) begin
    if (inFire) begin
      mem[wrAddr] <= wordIn;
      eopFlag[wrAddr] <= pktEop;
    end
    if (rqState == RQ_MEM) begin
      memQ <= mem[rdAddrReg];
    end
  end

  // Request pipeline: take, memory read, load, show until ready
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rqState <= RQ_IDLE;
      rdAddrReg <= '0;
      outValid <= 1'b0;
      outChannel <= '0;
      outData <= '0;
      outSop <= 1'b0;
      outEop <= 1'b0;
      outError <= '0;
    end else begin
      case (rqState)
        RQ_IDLE: begin
          if (reqGo) begin
            rdAddrReg <= rdAddrNow;
            outChannel <= reqChSel;
            rqState <= RQ_MEM;
          end
        end
        RQ_MEM: begin
          rqState <= RQ_LOAD;
        end
        RQ_LOAD: begin
          {outError, outEop, outSop, outData} <= memQ;
          outValid <= 1'b1;
          rqState <= RQ_SHOW;
        end
        RQ_SHOW: begin
          if (outReady) begin
            outValid <= 1'b0;
            rqState <= RQ_IDLE;
          end
        end
        default: begin
          rqState <= RQ_IDLE;
        end
      endcase
    end
  end

  // Control registers
  wire logic wrAf;
  wire logic wrAe;
  wire logic wrAf2;
  wire logic wrAe2;
  wire logic [REG_W-1:0] ctlRdSel;

  assign wrAf = ctlWr && (ctlAddr == AF_THR_OFS);
  assign wrAe = ctlWr && (ctlAddr == AE_THR_OFS);
  assign wrAf2 = ctlWr && (ctlAddr == AF2_THR_OFS);
  assign wrAe2 = ctlWr && (ctlAddr == AE2_THR_OFS);
  // Unmapped offsets read as zero
  assign ctlRdSel = (ctlAddr == AF_THR_OFS) ? afThr :
                    (ctlAddr == AE_THR_OFS) ? aeThr :
                    (ctlAddr == AF2_THR_OFS) ? af2Thr :
                    (ctlAddr == AE2_THR_OFS) ? ae2Thr : '0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      afThr <= THR_RST;
      aeThr <= THR_RST;
      af2Thr <= THR_RST;
      ae2Thr <= THR_RST;
      ctlRdata <= '0;
    end else begin
      if (wrAf) afThr <= ctlWdata;
      if (wrAe) aeThr <= ctlWdata;
      if (wrAf2) af2Thr <= ctlWdata;
      if (wrAe2) ae2Thr <= ctlWdata;
      ctlRdata <= ctlRd ? ctlRdSel : '0;
    end
  end

  // Fill-level port, one word per channel
  wire logic [CH_W-1:0] fillCh;
  wire logic [REG_W-1:0] fillSel;

  assign fillCh = fillAddr[FILL_ADDR_W-1:2];
  assign fillSel = (USE_FILL && (fillCh <= CH_LAST)) ? REG_W'(level[fillCh]) : '0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fillRdata <= '0;
    end else begin
      fillRdata <= fillRd ? fillSel : '0;
    end
  end

  // Threshold status, one channel per cycle
  wire logic [CH_W-1:0] chNext;
  wire logic [REG_W-1:0] lvlNext;
  wire logic [1:0] afHit;
  wire logic [1:0] aeHit;

  assign chNext = (afChannel == CH_LAST) ? '0 : afChannel + CH_W'(1);
  assign lvlNext = REG_W'(level[chNext]);
  assign afHit[0] = (NUM_AF >= 1) && (lvlNext >= afThr);
  assign afHit[1] = (NUM_AF == 2) && (lvlNext >= af2Thr);
  assign aeHit[0] = (NUM_AE >= 1) && (lvlNext <= aeThr);
  assign aeHit[1] = (NUM_AE == 2) && (lvlNext <= ae2Thr);
  assign aeValid = afValid;
  assign aeChannel = afChannel;

  // Starts at the last channel so channel 0 is shown first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      afValid <= 1'b0;
      afChannel <= CH_LAST;
      afData <= 2'h0;
      aeData <= 2'h0;
    end else begin
      afValid <= 1'b1;
      afChannel <= chNext;
      afData <= afHit;
      aeData <= aeHit;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_reqGranted;
    reqGo;
  endsequence

  sequence s_gapThenData;
    !outValid [*2] ##1 outValid;
  endsequence

  property p_reqLatency;
    s_reqGranted |=> s_gapThenData;
  endproperty
  a_reqLatency: assert property (p_reqLatency) else $error("request data not at cycle three");

  property p_oneOutstanding;
    s_reqGranted |=> !reqReady [*3];
  endproperty
  a_oneOutstanding: assert property (p_oneOutstanding) else $error("second request taken");

  property p_holdBeat;
    outValid && !outReady |=> outValid && $stable(outData) && $stable(outChannel);
  endproperty
  a_holdBeat: assert property (p_holdBeat) else $error("beat dropped without ready");

  property p_noDataIneligible;
    reqTake && !eligible[reqChSel] |=> !outValid [*3];
  endproperty
  a_noDataIneligible: assert property (p_noDataIneligible) else $error("data without packet");

  property p_roundRobin;
    afValid |=> (afChannel == CH_W'($past(afChannel) + CH_W'(1))) || (NUM_CH == 1);
  endproperty
  a_roundRobin: assert property (p_roundRobin) else $error("status channel skipped");

  property p_afPrimary;
    afValid |=> afData[0] == ((NUM_AF >= 1) && ($past(lvlNext) >= $past(afThr)));
  endproperty
  a_afPrimary: assert property (p_afPrimary) else $error("almost-full bit 0 wrong");

  property p_aeSecondary;
    afValid |=> aeData[1] == ((NUM_AE == 2) && ($past(lvlNext) <= $past(ae2Thr)));
  endproperty
  a_aeSecondary: assert property (p_aeSecondary) else $error("almost-empty bit 1 wrong");

  property p_fillRead;
    fillRd && !inFire && !reqGo && USE_FILL |=> fillRdata == REG_W'(level[$past(fillCh)]);
  endproperty
  a_fillRead: assert property (p_fillRead) else $error("fill level read wrong");

  property p_sharedThr;
    wrAf |=> afThr == $past(ctlWdata) ##1
      afData[0] == ((NUM_AF >= 1) && ($past(lvlNext) >= $past(afThr)));
  endproperty
  a_sharedThr: assert property (p_sharedThr) else $error("threshold write lost");

  property p_dropKeepsLevel;
    inFire && dropNow && !reqGo |=> level[$past(inChannel)] == $past(inLevel);
  endproperty
  a_dropKeepsLevel: assert property (p_dropKeepsLevel) else $error("dropped packet counted");

endmodule

//--- test/mcf_far_end.sv
// Downstream consumer model for the FIFO source port
`timescale 1ns/1ps
module mcf_far_end (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Source handshake
  input wire logic outValid,
  input wire logic [3:0] stall,
  output logic outReady
);
  logic [3:0] waitCnt;
  // Holding ready off proves the source keeps its beat standing
  assign outReady = outValid && (waitCnt >= stall);
  always_ff @(posedge clk_sys) begin
    if (rst || !outValid || outReady) begin
      waitCnt <= 4'h0;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

//--- test/test_mcf_fifo.sv
// Self-checking bench for the multichannel shared FIFO
`timescale 1ns/1ps
module test_mcf_fifo
  import mcf_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic inValid = 1'b0;
  logic inSop = 1'b0;
  logic inEop = 1'b0;
  logic reqWrite = 1'b0;
  logic ctlWr = 1'b0;
  logic ctlRd = 1'b0;
  logic fillRd = 1'b0;
  logic [DATA_W-1:0] inData = 32'h0;
  logic [CH_W-1:0] inChannel = 2'h0;
  logic [CH_W-1:0] reqAddr = 2'h0;
  logic [ERR_W-1:0] inError = 1'h0;
  logic [CTL_ADDR_W-1:0] ctlAddr = 4'h0;
  logic [REG_W-1:0] ctlWdata = 32'h0;
  logic [FILL_ADDR_W-1:0] fillAddr = 4'h0;
  logic [3:0] stall = 4'h0;
  logic inReady, outValid, outReady, outSop, outEop, reqReady, afValid, aeValid;
  logic [DATA_W-1:0] outData;
  logic [CH_W-1:0] outChannel, afChannel, aeChannel;
  logic [ERR_W-1:0] outError;
  logic [REG_W-1:0] ctlRdata, fillRdata;
  logic [1:0] afData, aeData;
  int n_errors = 0;
  int checks_done = 0;
  // Thresholds in offset order: af, ae, af2, ae2
  logic [REG_W-1:0] thr [4] = '{32'h2, 32'h1, 32'h3, 32'h0};
  int lvl [4] = '{0, 0, 0, 0};

  mcf_fifo u_mcf_fifo (
    .clk_sys, .rst, .inValid, .inReady, .inData, .inChannel, .inSop, .inEop, .inError,
    .outValid, .outReady, .outData, .outChannel, .outSop, .outEop, .outError,
    .reqWrite, .reqAddr, .reqReady, .ctlAddr, .ctlWdata, .ctlWr, .ctlRd, .ctlRdata,
    .fillAddr, .fillRd, .fillRdata, .afValid, .afData, .afChannel,
    .aeValid, .aeData, .aeChannel
  );
  mcf_far_end u_mcf_far_end (.clk_sys, .rst, .outValid, .stall, .outReady);

  always #2 clk_sys = ~clk_sys;

  task automatic stop_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic put(input logic [CH_W-1:0] ch, input logic [31:0] d, input logic s, e, er);
    int k;
    inValid <= 1'b1;
    inChannel <= ch;
    inData <= d;
    inSop <= s;
    inEop <= e;
    inError <= er;
    for (k = 0; k < 50; k++) begin
      @(negedge clk_sys);
      if (inReady === 1'b1) break;
      @(posedge clk_sys);
    end
    if (k == 50) begin
      chk(64'h0, 64'h1, "sink never ready");
      stop_test();
    end
    @(posedge clk_sys);
  endtask

  task automatic idle_in();
    inValid <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic pkt(input logic [CH_W-1:0] ch, input int n, input logic [31:0] b, input logic er);
    int i;
    for (i = 0; i < n; i++) put(ch, b + 32'(i), i == 0, i == n - 1, er && i == n - 1);
    idle_in();
  endtask

  task automatic bus_rd(input bit fill, input logic [3:0] a, input logic [31:0] exp, string m);
    if (fill) begin
      fillRd <= 1'b1;
      fillAddr <= a;
    end else begin
      ctlRd <= 1'b1;
      ctlAddr <= a;
    end
    @(posedge clk_sys);
    fillRd <= 1'b0;
    ctlRd <= 1'b0;
    @(negedge clk_sys);
    chk(fill ? fillRdata : ctlRdata, exp, m);
    @(posedge clk_sys);
  endtask

  task automatic ctl_wr(input logic [3:0] a, input logic [31:0] d);
    ctlWr <= 1'b1;
    ctlAddr <= a;
    ctlWdata <= d;
    @(posedge clk_sys);
    ctlWr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic req(input logic [CH_W-1:0] ch, input logic [3:0] st, input logic [31:0] d,
                     input logic s, e);
    int k;
    stall <= st;
    reqWrite <= 1'b1;
    reqAddr <= ch;
    @(negedge clk_sys);
    chk(reqReady, 1'b1, "request refused");
    @(posedge clk_sys);
    reqWrite <= 1'b0;
    repeat (2) begin
      @(negedge clk_sys);
      chk({outValid, reqReady}, 2'b00, "data too early or second request open");
    end
    @(negedge clk_sys);
    chk({outValid, outData, outChannel, outSop, outEop, outError}, {1'b1, d, ch, s, e, 1'b0}, "beat");
    for (k = 0; k < 8 && outReady !== 1'b1; k++) begin
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk({outValid, outData}, {1'b1, d}, "beat not held");
    end
    chk(outReady, 1'b1, "no handshake");
    if (outReady !== 1'b1) stop_test();
    @(posedge clk_sys);
  endtask

  task automatic req_none(input logic [CH_W-1:0] ch);
    reqWrite <= 1'b1;
    reqAddr <= ch;
    @(posedge clk_sys);
    reqWrite <= 1'b0;
    repeat (8) begin
      @(negedge clk_sys);
      chk(outValid, 1'b0, "data without whole packet");
    end
    @(posedge clk_sys);
  endtask

  // Levels stay still while walking so one cycle of status lag is harmless
  task automatic stat_chk();
    logic [CH_W-1:0] c;
    int l;
    @(negedge clk_sys);
    c = afChannel;
    repeat (8) begin
      @(negedge clk_sys);
      c = c + 2'h1;
      l = lvl[c];
      chk(afChannel, c, "status order");
      chk({afValid, aeValid, aeChannel, afData, aeData},
          {2'b11, c, l >= thr[2], l >= thr[0], l <= thr[3], l <= thr[1]}, "status");
    end
    @(posedge clk_sys);
  endtask

  initial begin
    int i;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    for (i = 0; i < 4; i++) bus_rd(0, 4'(4 * i), 32'h0, "threshold reset");
    for (i = 0; i < 4; i++) ctl_wr(4'(4 * i), thr[i]);
    for (i = 0; i < 4; i++) bus_rd(0, 4'(4 * i), thr[i], "threshold");
    ctl_wr(4'h2, 32'h7);
    bus_rd(0, 4'h2, 32'h0, "unmapped offset");
    bus_rd(0, 4'h0, thr[0], "threshold after unmapped write");
    pkt(2'h1, 3, 32'h0000_a100, 1'b0);
    lvl[1] = 3;
    pkt(2'h2, 2, 32'h0000_b200, 1'b1);
    put(2'h3, 32'h0000_c300, 1'b1, 1'b0, 1'b0);
    idle_in();
    for (i = 0; i < 4; i++) bus_rd(1, 4'(4 * i), 32'(lvl[i]), "fill level");
    stat_chk();
    req(2'h1, 4'h0, 32'h0000_a100, 1'b1, 1'b0);
    req(2'h1, 4'h3, 32'h0000_a101, 1'b0, 1'b0);
    req(2'h1, 4'h0, 32'h0000_a102, 1'b0, 1'b1);
    lvl[1] = 0;
    bus_rd(1, 4'h4, 32'h0, "level after drain");
    pkt(2'h0, 16, 32'h0000_d000, 1'b0);
    lvl[0] = 16;
    inValid <= 1'b1;
    inChannel <= 2'h0;
    @(negedge clk_sys);
    chk(inReady, 1'b0, "segment overfilled");
    @(posedge clk_sys);
    inValid <= 1'b0;
    bus_rd(1, 4'h0, 32'h10, "full level");
    stat_chk();
    req_none(2'h2);
    req_none(2'h3);
    stop_test();
  end
endmodule
